/* File: hw/aux_io_pkg.sv */
// constants, register map and carrier types of the auxiliary digital i/o block
// Notes on behaviour
// - rising input edge launches its configured action
// - falling input edge launches second configured action
// - per-input filter length 0 to 10,000,000 ms
// - each output driven from one selected source
// - fault source: 1 after fault, else 0
// - form source: 1 single, 0 split/three phase
// - relay source: 1 closed and enabled, 0 open
// - program source: 1 program selected, 0 manual
// - remote source: 1 remote, 0 local control
// - transient source: 1 running/paused/stepping, 0 stopped
// - coupling source: 1 transformer, 0 direct coupled
// - per-output polarity inversion complements selected source
// - outputs three/four: 1 turns driver on, line low
// - trigger enable; immediate ignores phase update point
// - run_without_command: trigger starts transient without run
// - strobe pulses on selected start/relay/parameter events
// - inhibit mode: relay closes only with contact closed
// - enable mode: contact or panel controls relay
// - disabled mode: contact has no relay influence
// - sync locks to connector or line, 0.10-5000 Hz
package aux_io_pkg;

  localparam int  CLK_HZ         = 50_000_000;
  localparam int  FILT_MS_MAX    = 10_000_000;
  localparam int  FILT_W         = 24;
  localparam int  MS_CYC         = CLK_HZ / 1000;
  localparam int  SYNC_FMAX_HZ   = 5000;
  localparam int  SYNC_FMIN_CHZ  = 10;
  localparam longint SYNC_MIN_CYC = longint'(CLK_HZ) / SYNC_FMAX_HZ;
  localparam longint SYNC_MAX_CYC = longint'(CLK_HZ) * 100 / SYNC_FMIN_CHZ;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DOUT   = 8'h04;
  localparam logic [7:0] OFS_ACT    = 8'h08;
  localparam logic [7:0] OFS_FILT0  = 8'h0C;
  localparam logic [7:0] OFS_PHASE  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  localparam int CTRL_TRIG_EN   = 0;
  localparam int CTRL_TRIG_IMM  = 1;
  localparam int CTRL_RUN_NOCMD = 2;
  localparam int CTRL_STRB_TRAN = 3;
  localparam int CTRL_STRB_RLY  = 4;
  localparam int CTRL_STRB_PAR  = 5;
  localparam int CTRL_CMODE     = 6;
  localparam int CTRL_SYNC_EN   = 8;
  localparam int CTRL_SYNC_LINE = 9;
  localparam int DOUT_INV       = 4;
  localparam int ACT_FALL       = 8;

  localparam logic [9:0]  CTRL_RST  = 10'h000;
  localparam logic [31:0] DOUT_RST  = 32'h03030303;
  localparam logic [5:0]  ACT_RST   = 6'h00;
  localparam logic [15:0] PHASE_RST = 16'h0000;

  typedef enum logic [3:0] {
    SRC_FAULT = 4'h0, SRC_FORM = 4'h1, SRC_HIGH = 4'h2, SRC_LOW = 4'h3,
    SRC_RELAY = 4'h4, SRC_PROG = 4'h5, SRC_REMOTE = 4'h6, SRC_TRANS = 4'h7,
    SRC_XFMR = 4'h8
  } out_src_e;

  typedef enum logic [1:0] {
    CMODE_OFF = 2'h0, CMODE_INHIBIT = 2'h1, CMODE_ENABLE = 2'h2
  } contact_mode_e;

  // conditions reported by the instrument core
  typedef struct packed {
    logic fault;
    logic form_single;
    logic relay_closed;
    logic program_sel;
    logic remote_ctl;
    logic trans_active;
    logic xfmr_coupled;
    logic trans_start;
    logic param_change;
    logic phase_point;
    logic run_armed;
    logic line_sync;
  } inst_state_s;

endpackage : aux_io_pkg

/* File: hw/aux_digital_io_events.sv */
// auxiliary digital i/o: filtered inputs, source-selected outputs, trigger, strobe, sync
`timescale 1ns/1ps
`default_nettype none
module aux_digital_io_events #(
  parameter int     FILT_W       = aux_io_pkg::FILT_W,
  parameter longint SYNC_MIN_CYC = aux_io_pkg::SYNC_MIN_CYC,
  parameter longint SYNC_MAX_CYC = aux_io_pkg::SYNC_MAX_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire aux_io_pkg::inst_state_s inst,
  input  wire logic [2:0]              din,
  input  wire logic                    trig_in,
  input  wire logic                    contact_closed,
  input  wire logic                    panel_relay_req,
  input  wire logic                    ext_sync_in,
  input  wire logic [1:0]              od_in,
  output logic [1:0]                   dout,
  output logic [1:0]                   od_out,
  output logic [1:0]                   od_oe,
  output logic [2:0]                   rise_act,
  output logic [2:0]                   fall_act,
  output logic                         trans_go,
  output logic                         strobe,
  output logic                         relay_cmd,
  output logic                         sync_edge,
  output logic                         sync_lock,
  output logic [15:0]                  phase_ofs
);

  if (FILT_W < 24 || FILT_W > 32) begin : g_chk_filt
    $error("FILT_W must hold 10,000,000 and stay within 32 bits");
  end
  if (SYNC_MIN_CYC < 1 || SYNC_MAX_CYC < SYNC_MIN_CYC || SYNC_MAX_CYC > 64'h7FFFFFFF) begin : g_chk_sync
    $error("sync period bounds out of range");
  end

  localparam logic [31:0] MIN_C = 32'(SYNC_MIN_CYC);
  localparam logic [31:0] MAX_C = 32'(SYNC_MAX_CYC);
  localparam logic [15:0] MS_C  = 16'(aux_io_pkg::MS_CYC - 1);

  typedef struct packed {
    logic [9:0]              ctrl;
    logic [31:0]             dcfg;
    logic [5:0]              act;
    logic [2:0][FILT_W-1:0]  flen;
    logic [15:0]             phase;
    logic [15:0]             ms_cnt;
    logic                    ms_tick;
    logic [2:0]              stable;
    logic [2:0][FILT_W-1:0]  fcnt;
    logic [1:0]              dout;
    logic [1:0]              od_oe;
    logic [2:0]              rise;
    logic [2:0]              fall;
    logic                    trig_prev;
    logic                    trig_pend;
    logic                    go;
    logic                    strobe;
    logic                    relay_prev;
    logic                    relay_cmd;
    logic                    sync_prev;
    logic                    sync_edge;
    logic [31:0]             sync_cnt;
    logic                    sync_lock;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } state_s;

  state_s st_q;
  state_s st_d;

  // one selectable condition per output channel
  function automatic logic src_val(input logic [3:0] sel, input aux_io_pkg::inst_state_s s);
    logic v;
    v = 1'b0;
    case (sel)
      aux_io_pkg::SRC_FAULT:  v = s.fault;
      aux_io_pkg::SRC_FORM:   v = s.form_single;
      aux_io_pkg::SRC_HIGH:   v = 1'b1;
      aux_io_pkg::SRC_LOW:    v = 1'b0;
      aux_io_pkg::SRC_RELAY:  v = s.relay_closed;
      aux_io_pkg::SRC_PROG:   v = s.program_sel;
      aux_io_pkg::SRC_REMOTE: v = s.remote_ctl;
      aux_io_pkg::SRC_TRANS:  v = s.trans_active;
      aux_io_pkg::SRC_XFMR:   v = s.xfmr_coupled;
      default:                v = 1'b0;
    endcase
    return v;
  endfunction : src_val

  function automatic logic [7:0] ch_cfg(input logic [31:0] d, input int ch);
    return d[ch*8 +: 8];
  endfunction : ch_cfg

  logic [2:0]  din_in;
  logic        sref;
  logic [31:0] status;
  logic [1:0]  cmode;
  logic [7:0]  cfg;
  logic        ov;
  logic        hit;

  always_comb begin
    st_d    = st_q;
    din_in  = din;
    cmode   = st_q.ctrl[aux_io_pkg::CTRL_CMODE +: 2];
    cfg     = 8'h00;
    ov      = 1'b0;
    hit     = 1'b0;

    // millisecond time base for the input filters
    st_d.ms_tick = (st_q.ms_cnt == MS_C);
    st_d.ms_cnt  = st_d.ms_tick ? 16'h0000 : st_q.ms_cnt + 16'h0001;

    st_d.rise = 3'h0;
    st_d.fall = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (din_in[i] == st_q.stable[i]) begin
        st_d.fcnt[i] = '0;
      end else if (st_q.flen[i] == '0 ||
                   (st_q.ms_tick && st_q.fcnt[i] + FILT_W'(1) >= st_q.flen[i])) begin
        st_d.stable[i] = din_in[i];
        st_d.fcnt[i]   = '0;
        st_d.rise[i]   = din_in[i] & st_q.act[i];
        st_d.fall[i]   = ~din_in[i] & st_q.act[aux_io_pkg::ACT_FALL - 5 + i];
      end else if (st_q.ms_tick) begin
        st_d.fcnt[i] = st_q.fcnt[i] + FILT_W'(1);
      end
    end

    for (int c = 0; c < 4; c++) begin
      cfg = ch_cfg(st_q.dcfg, c);
      ov  = src_val(cfg[3:0], inst) ^ cfg[aux_io_pkg::DOUT_INV];
      if (c < 2) begin
        st_d.dout[c] = ov;
      end else begin
        st_d.od_oe[c-2] = ov;
      end
    end

    // trigger: immediate fires now, otherwise waits for the phase update point
    st_d.trig_prev = trig_in;
    st_d.go        = 1'b0;
    if (!st_q.ctrl[aux_io_pkg::CTRL_TRIG_EN]) begin
      st_d.trig_pend = 1'b0;
    end else if ((trig_in && !st_q.trig_prev) || st_q.trig_pend) begin
      if (st_q.ctrl[aux_io_pkg::CTRL_TRIG_IMM] || inst.phase_point) begin
        st_d.trig_pend = 1'b0;
        st_d.go = inst.run_armed | st_q.ctrl[aux_io_pkg::CTRL_RUN_NOCMD];
      end else begin
        st_d.trig_pend = 1'b1;
      end
    end

    st_d.relay_prev = inst.relay_closed;
    st_d.strobe = (st_q.ctrl[aux_io_pkg::CTRL_STRB_TRAN] & inst.trans_start) |
                  (st_q.ctrl[aux_io_pkg::CTRL_STRB_RLY] & inst.relay_closed & ~st_q.relay_prev) |
                  (st_q.ctrl[aux_io_pkg::CTRL_STRB_PAR] & inst.param_change);

    case (cmode)
      aux_io_pkg::CMODE_INHIBIT: st_d.relay_cmd = panel_relay_req & contact_closed;
      aux_io_pkg::CMODE_ENABLE:  st_d.relay_cmd = panel_relay_req | contact_closed;
      default:                   st_d.relay_cmd = panel_relay_req;
    endcase

    // sync: lock only while the reference period stays inside the frequency band
    sref = st_q.ctrl[aux_io_pkg::CTRL_SYNC_LINE] ? inst.line_sync : ext_sync_in;
    sref = sref & st_q.ctrl[aux_io_pkg::CTRL_SYNC_EN];
    st_d.sync_prev = sref;
    st_d.sync_edge = sref & ~st_q.sync_prev;
    if (!st_q.ctrl[aux_io_pkg::CTRL_SYNC_EN]) begin
      st_d.sync_lock = 1'b0;
      st_d.sync_cnt  = 32'h00000000;
    end else if (sref && !st_q.sync_prev) begin
      st_d.sync_lock = (st_q.sync_cnt >= MIN_C) && (st_q.sync_cnt <= MAX_C);
      st_d.sync_cnt  = 32'h00000000;
    end else if (st_q.sync_cnt > MAX_C) begin
      st_d.sync_lock = 1'b0;
    end else begin
      st_d.sync_cnt = st_q.sync_cnt + 32'h00000001;
    end

    // apb slave, answers in the first access cycle
    status = {20'h00000, st_q.trig_pend, st_q.sync_lock, st_q.relay_cmd,
              od_in, st_q.od_oe, st_q.dout, st_q.stable};
    st_d.pready  = psel & ~penable;
    st_d.pslverr = 1'b0;
    if (psel && !penable) begin
      hit = 1'b1;
      case (paddr)
        aux_io_pkg::OFS_CTRL:          st_d.prdata = {22'h000000, st_q.ctrl};
        aux_io_pkg::OFS_DOUT:          st_d.prdata = st_q.dcfg;
        aux_io_pkg::OFS_ACT:           st_d.prdata = {21'h000000, st_q.act[5:3], 5'h00, st_q.act[2:0]};
        aux_io_pkg::OFS_FILT0:         st_d.prdata = 32'(st_q.flen[0]);
        aux_io_pkg::OFS_FILT0 + 8'h04: st_d.prdata = 32'(st_q.flen[1]);
        aux_io_pkg::OFS_FILT0 + 8'h08: st_d.prdata = 32'(st_q.flen[2]);
        aux_io_pkg::OFS_PHASE:         st_d.prdata = {16'h0000, st_q.phase};
        aux_io_pkg::OFS_STATUS:        st_d.prdata = status;
        default: begin
          st_d.prdata  = 32'h00000000;
          st_d.pslverr = 1'b1;
          hit = 1'b0;
        end
      endcase
    end
    if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
      case (paddr)
        aux_io_pkg::OFS_CTRL:          st_d.ctrl  = pwdata[9:0];
        aux_io_pkg::OFS_DOUT:          st_d.dcfg  = pwdata;
        aux_io_pkg::OFS_ACT:           st_d.act   = {pwdata[10:8], pwdata[2:0]};
        aux_io_pkg::OFS_FILT0:         st_d.flen[0] = pwdata[FILT_W-1:0];
        aux_io_pkg::OFS_FILT0 + 8'h04: st_d.flen[1] = pwdata[FILT_W-1:0];
        aux_io_pkg::OFS_FILT0 + 8'h08: st_d.flen[2] = pwdata[FILT_W-1:0];
        aux_io_pkg::OFS_PHASE:         st_d.phase = pwdata[15:0];
        default: ;
      endcase
    end
    if (!hit && !(psel && !penable)) begin
      st_d.prdata = st_q.prdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q       <= '0;
      st_q.ctrl  <= aux_io_pkg::CTRL_RST;
      st_q.dcfg  <= aux_io_pkg::DOUT_RST;
      st_q.act   <= aux_io_pkg::ACT_RST;
      st_q.phase <= aux_io_pkg::PHASE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata    = st_q.prdata;
  assign pready    = st_q.pready;
  assign pslverr   = st_q.pslverr;
  assign dout      = st_q.dout;
  assign od_out    = 2'b00;
  assign od_oe     = st_q.od_oe;
  assign rise_act  = st_q.rise;
  assign fall_act  = st_q.fall;
  assign trans_go  = st_q.go;
  assign strobe    = st_q.strobe;
  assign relay_cmd = st_q.relay_cmd;
  assign sync_edge = st_q.sync_edge;
  assign sync_lock = st_q.sync_lock;
  assign phase_ofs = st_q.phase;

  property p_filt_zero;
    @(posedge core_clk) disable iff (reset)
      (st_q.flen[0] == '0 && din[0] != st_q.stable[0]) |=> (st_q.stable[0] == $past(din[0]));
  endproperty
  a_filt_zero: assert property (p_filt_zero) else $error("zero-length filter did not pass level");

  property p_rise_act;
    @(posedge core_clk) disable iff (reset)
      $rose(st_q.stable[1]) |-> (rise_act[1] == $past(st_q.act[1]));
  endproperty
  a_rise_act: assert property (p_rise_act) else $error("rising edge action mismatch");

  property p_fall_act;
    @(posedge core_clk) disable iff (reset)
      $fell(st_q.stable[2]) |-> (fall_act[2] == $past(st_q.act[5]));
  endproperty
  a_fall_act: assert property (p_fall_act) else $error("falling edge action mismatch");

  property p_fault_src;
    @(posedge core_clk) disable iff (reset)
      (st_q.dcfg[7:0] == 8'h00) |=> (dout[0] == $past(inst.fault));
  endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault source not on output one");

  property p_inv_low;
    @(posedge core_clk) disable iff (reset)
      (st_q.dcfg[15:8] == 8'h13) [*2] |-> dout[1];
  endproperty
  a_inv_low: assert property (p_inv_low) else $error("inverted low source not high");

  property p_od_high;
    @(posedge core_clk) disable iff (reset)
      (st_q.dcfg[23:16] == 8'h02) |=> od_oe[0] && !od_out[0];
  endproperty
  a_od_high: assert property (p_od_high) else $error("open-drain driver not on for logic 1");

  property p_inhibit;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[7:6] == 2'h1 && !contact_closed) |=> !relay_cmd;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("relay closed without contact");

  property p_enable;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[7:6] == 2'h2 && (contact_closed || panel_relay_req)) |=> relay_cmd;
  endproperty
  a_enable: assert property (p_enable) else $error("contact or panel ignored in enable mode");

  property p_contact_off;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[7:6] == 2'h0) |=> (relay_cmd == $past(panel_relay_req));
  endproperty
  a_contact_off: assert property (p_contact_off) else $error("contact influenced relay when off");

  property p_trig_imm;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[2:0] == 3'h7 && trig_in && !st_q.trig_prev) |=> trans_go ##1 !trans_go;
  endproperty
  a_trig_imm: assert property (p_trig_imm) else $error("immediate run_without_command trigger missed");

  property p_strobe_par;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[5] && inst.param_change) |=> strobe;
  endproperty
  a_strobe_par: assert property (p_strobe_par) else $error("parameter change strobe missing");

  property p_strobe_rly;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[4] && inst.relay_closed && !st_q.relay_prev) |=> strobe;
  endproperty
  a_strobe_rly: assert property (p_strobe_rly) else $error("relay close strobe missing");

  property p_trig_wait;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[1:0] == 2'h1 && st_q.trig_pend && !inst.phase_point) |=> !trans_go;
  endproperty
  a_trig_wait: assert property (p_trig_wait) else $error("trigger fired before update point");

  property p_trig_off;
    @(posedge core_clk) disable iff (reset)
      (!st_q.ctrl[0] && trig_in && !st_q.trig_prev) |=> !trans_go;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("disabled trigger fired");

  property p_sync_band;
    @(posedge core_clk) disable iff (reset)
      (st_q.ctrl[8] && st_q.sync_cnt > MAX_C) |=> !sync_lock;
  endproperty
  a_sync_band: assert property (p_sync_band) else $error("lock held outside frequency band");

  property p_xfmr_src;
    @(posedge core_clk) disable iff (reset)
      (st_q.dcfg[31:24] == 8'h08) |=> (od_oe[1] == $past(inst.xfmr_coupled));
  endproperty
  a_xfmr_src: assert property (p_xfmr_src) else $error("coupling source not on output four");

endmodule : aux_digital_io_events
`default_nettype wire

/* File: dv/plc_partner.sv */
// far-side equipment model: digital inputs, pulled-up open-drain lines, sync reference
`timescale 1ns/1ps
`default_nettype none
module plc_partner (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [2:0] din_set,
  input  wire logic [7:0] sync_half,
  input  wire logic [1:0] od_oe,
  output logic      [2:0] din,
  output logic      [1:0] od_in,
  output logic            ext_sync_in
);
  logic [7:0] cnt_q;

  // the 1k pull-up wins whenever the fet is off, so the line reads the inverse
  assign od_in = ~od_oe;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      din         <= 3'h0;
      cnt_q       <= 8'h00;
      ext_sync_in <= 1'b0;
    end else begin
      din <= din_set;
      // reference stands low while no period is commanded
      if (sync_half == 8'h00) begin
        cnt_q       <= 8'h00;
        ext_sync_in <= 1'b0;
      end else if (cnt_q >= sync_half - 8'h01) begin
        cnt_q       <= 8'h00;
        ext_sync_in <= ~ext_sync_in;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : plc_partner
`default_nettype wire

/* File: dv/aux_digital_io_events_test.sv */
// self-checking bench for the auxiliary digital i/o block
`timescale 1ns/1ps
`default_nettype none
module aux_digital_io_events_test;
  logic                    core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]              paddr, sync_half;
  logic [31:0]             pwdata, prdata;
  aux_io_pkg::inst_state_s inst;
  logic [2:0]              din_set, din, rise_act, fall_act;
  logic                    trig_in, contact_closed, panel_relay_req, ext_sync_in;
  logic [1:0]              od_in, dout, od_oe, od_out;
  logic                    trans_go, strobe, relay_cmd, sync_lock, sync_edge;
  logic [15:0]             phase_ofs;
  int                      fails, n_tests, seed, n_go, n_strb, n_sync;
  int                      n_rise [3];
  int                      n_fall [3];

  aux_digital_io_events #(.SYNC_MIN_CYC(4), .SYNC_MAX_CYC(40)) u_aux_digital_io_events (
    .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .inst, .din, .trig_in, .contact_closed, .panel_relay_req, .ext_sync_in,
    .od_in, .dout, .od_out, .od_oe, .rise_act, .fall_act, .trans_go, .strobe,
    .relay_cmd, .sync_edge, .sync_lock, .phase_ofs);

  plc_partner u_plc_partner (
    .core_clk, .reset, .din_set, .sync_half, .od_oe, .din, .od_in, .ext_sync_in);

  always #10 core_clk = ~core_clk;

  // pulses are counted mid-cycle so clearing at a rising edge never races them
  always @(negedge core_clk) begin
    for (int k = 0; k < 3; k++) begin
      n_rise[k] += int'(rise_act[k] === 1'b1);
      n_fall[k] += int'(fall_act[k] === 1'b1);
    end
    n_go   += int'(trans_go === 1'b1);
    n_strb += int'(strobe === 1'b1);
    n_sync += int'(sync_edge === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
    n_tests++;
    if (got !== x) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, x);
    end
  endtask : chk

  task automatic clr();
    n_rise = '{0, 0, 0};
    n_fall = '{0, 0, 0};
    n_go   = 0;
    n_strb = 0;
    n_sync = 0;
  endtask : clr

  // entered just after a rising edge; leaves one edge after the edge that took the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1, "wait states");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps back-to-back calls from retoggling psel in one time step
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
  endtask : rdc

  function automatic logic src_val(input logic [3:0] s, input logic v);
    logic x;
    case (s)
      4'h0: x = inst.fault;
      4'h1: x = inst.form_single;
      4'h2: x = 1'b1;
      4'h4: x = inst.relay_closed;
      4'h5: x = inst.program_sel;
      4'h6: x = inst.remote_ctl;
      4'h7: x = inst.trans_active;
      4'h8: x = inst.xfmr_coupled;
      default: x = 1'b0;
    endcase
    return x ^ v;
  endfunction : src_val

  task automatic trig(input logic [31:0] c, input logic arm, input logic pp, input logic x);
    wr(aux_io_pkg::OFS_CTRL, 32'h0);
    wr(aux_io_pkg::OFS_CTRL, c);
    inst.run_armed <= arm;
    clr();
    trig_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    trig_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    if (pp) begin
      chk(32'(n_go), 32'h0, "early go");
      inst.phase_point <= 1'b1;
      @(posedge core_clk);
      inst.phase_point <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    chk(32'(n_go), 32'(x), "go");
  endtask : trig

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
    logic [3:0]  s [4];
    logic        v [4];
    logic [5:0]  a;
    logic [2:0]  nd;
    logic [2:0]  od;
    logic [3:0]  ox;
    int          n;
    {core_clk, reset, psel, penable, pwrite, trig_in, contact_closed, panel_relay_req} = 8'h40;
    {paddr, sync_half, pwdata, din_set} = '0;
    inst = '0;
    seed = 60;
    clr();
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk(32'({dout, od_oe}), 32'h0, "idle outputs");
    rdc(aux_io_pkg::OFS_CTRL, 32'h0, "ctrl rst");
    rdc(aux_io_pkg::OFS_DOUT, 32'h0303_0303, "dout rst");
    rdc(aux_io_pkg::OFS_ACT, 32'h0, "act rst");
    rdc(aux_io_pkg::OFS_PHASE, 32'h0, "phase rst");
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, r, e);
    chk(32'(e), 32'h1, "slverr");
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(r, 32'h0, "unmapped");
    for (int i = 0; i < 18; i++) begin
      inst <= 12'($random(seed));
      w = 32'h0;
      for (int c = 0; c < 4; c++) begin
        s[c] = 4'((i + 2 * c) % 9);
        // first pass walks every source uninverted, the next two force inversion
        v[c] = (i < 9) ? 1'b0 : (i < 11) ? 1'b1 : 1'($random(seed));
        w[c*8 +: 5] = {v[c], s[c]};
      end
      wr(aux_io_pkg::OFS_DOUT, w);
      repeat (2) @(posedge core_clk);
      ox = {src_val(s[1], v[1]), src_val(s[0], v[0]), src_val(s[3], v[3]), src_val(s[2], v[2])};
      chk(32'({dout, od_oe, od_out}), 32'({ox, 2'b00}), "outputs");
      rdc(aux_io_pkg::OFS_STATUS, {23'h0, ~ox[1:0], ox[1:0], ox[3:2], 3'h0}, "status");
    end
    inst <= '0;
    for (int i = 0; i < 8; i++) begin
      a  = 6'($random(seed));
      nd = 3'($random(seed));
      wr(aux_io_pkg::OFS_ACT, {21'h0, a[5:3], 5'h0, a[2:0]});
      clr();
      od = din_set;
      din_set <= nd;
      repeat (6) @(posedge core_clk);
      for (int k = 0; k < 3; k++) begin
        chk(32'(n_rise[k]), 32'(a[k] & nd[k] & ~od[k]), "rise");
        chk(32'(n_fall[k]), 32'(a[k+3] & od[k] & ~nd[k]), "fall");
      end
    end
    wr(aux_io_pkg::OFS_FILT0 + 8'h04, 32'd10_000_000);
    rdc(aux_io_pkg::OFS_FILT0 + 8'h04, 32'd10_000_000, "filt max");
    wr(aux_io_pkg::OFS_FILT0, 32'h1);
    wr(aux_io_pkg::OFS_ACT, 32'h0000_0707);
    clr();
    din_set <= din_set ^ 3'h1;
    n = 0;
    while (n_rise[0] + n_fall[0] == 0 && n < 50100) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    chk(32'(n_rise[0] + n_fall[0]), 32'h1, "filtered edge");
    trig(32'h7, 1'b0, 1'b0, 1'b1);
    trig(32'h3, 1'b0, 1'b0, 1'b0);
    trig(32'h3, 1'b1, 1'b0, 1'b1);
    trig(32'h5, 1'b0, 1'b1, 1'b1);
    trig(32'h6, 1'b1, 1'b0, 1'b0);
    inst <= '0;
    for (int k = 0; k < 6; k++) begin
      wr(aux_io_pkg::OFS_CTRL, 32'(k[0]) << (3 + k / 2));
      clr();
      case (k / 2)
        0: inst.trans_start <= 1'b1;
        1: inst.relay_closed <= 1'b1;
        default: inst.param_change <= 1'b1;
      endcase
      @(posedge core_clk);
      inst <= '0;
      repeat (4) @(posedge core_clk);
      chk(32'(n_strb), 32'(k[0]), "strobe");
    end
    for (int m = 0; m < 3; m++) begin
      wr(aux_io_pkg::OFS_CTRL, 32'(m) << 6);
      for (int k = 0; k < 4; k++) begin
        contact_closed  <= k[0];
        panel_relay_req <= k[1];
        repeat (3) @(posedge core_clk);
        chk(32'(relay_cmd), 32'(m == 0 ? k[1] : m == 1 ? k[0] & k[1] : k[0] | k[1]),
            "relay");
      end
    end
    wr(aux_io_pkg::OFS_CTRL, 32'h100);
    clr();
    sync_half <= 8'h05;
    repeat (60) @(posedge core_clk);
    chk(32'(sync_lock), 32'h1, "sync lock");
    chk(32'(n_sync), 32'h6, "sync edges");
    // a 60-cycle reference period lies outside the 4..40 band
    sync_half <= 8'h1E;
    repeat (80) @(posedge core_clk);
    chk(32'(sync_lock), 32'h0, "sync out of band");
    // line reference at a 10-cycle period while the connector stays slow
    wr(aux_io_pkg::OFS_CTRL, 32'h300);
    repeat (12) begin
      inst.line_sync <= ~inst.line_sync;
      repeat (5) @(posedge core_clk);
    end
    chk(32'(sync_lock), 32'h1, "sync line");
    w = {16'h0, 16'($random(seed))};
    wr(aux_io_pkg::OFS_PHASE, w);
    @(posedge core_clk);
    chk(32'(phase_ofs), w, "phase");
    rdc(aux_io_pkg::OFS_PHASE, w, "phase rd");
    // mid-run reset with the relay inputs idle, then the phase and ctrl registers must be back at reset
    reset           <= 1'b1;
    panel_relay_req <= 1'b0;
    contact_closed  <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rdc(aux_io_pkg::OFS_PHASE, 32'h0, "phase after reset");
    rdc(aux_io_pkg::OFS_CTRL, 32'h0, "ctrl after reset");
    conclude();
  end

  // the run is one 50000-cycle filter tick plus a few hundred cycles of other scenarios
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    $display("unexpected at %0t: watchdog", $time);
    conclude();
  end
endmodule : aux_digital_io_events_test
`default_nettype wire
